/* hw/dbg_port_pkg.sv */
// Constants shared by the serial debug port shifter
package dbg_port_pkg;
    // Shift register layout: start, mode, control, then 32 data bits
    localparam int          SHIFT_W        = 35;
    localparam int          DATA_W         = 32;
    localparam int          TRAP_W         = 9;
    localparam int          START_POS      = 34;
    localparam int          MODE_POS       = 33;
    localparam int          CTRL_POS       = 32;
    localparam logic [5:0]  LAST_BIT_IDX   = 6'h22;
    localparam logic [34:0] SHIFT_RESET    = 35'h000000000;
    localparam logic [8:0]  TRAP_RESET     = 9'h000;
    // Trap enable control register fields
    localparam int          TRAP_EN_LSB    = 0;
    localparam int          BRKPT_LSB      = 6;
    localparam int          SYNC_POS       = 8;
    // Register port map
    localparam int          ADDR_W         = 3;
    localparam logic [2:0]  ADDR_INSTR     = 3'h0;
    localparam logic [2:0]  ADDR_DATA      = 3'h1;
    localparam logic [2:0]  ADDR_STATUS    = 3'h2;
    localparam logic [2:0]  ADDR_CONFIG    = 3'h3;
    // Configuration register fields and reset values
    localparam int          CFG_CLK_MODE   = 0;
    localparam int          CFG_DEBUG_PIN_CONFIG_FIELD_LSB   = 1;
    localparam int          CFG_GPC_LSB    = 3;
    localparam int          CFG_FLUSH_SEL  = 5;
    localparam logic [1:0]  GPC_RESET      = 2'h0;
    localparam logic [1:0]  GPC_FREEZE     = 2'h1;
    localparam logic [1:0]  GPC_GPIO       = 2'h2;
    localparam logic [1:0]  DEBUG_PIN_CONFIG_FIELD_FLUSH     = 2'h1;
    localparam logic        CLK_MODE_RESET = 1'b0;
    localparam logic        FLUSH_SEL_RST  = 1'b0;
    localparam logic [1:0]  FROZEN_FLUSH   = 2'h3;
    // Status register fields
    localparam int          ST_RX_PEND     = 0;
    localparam int          ST_CLK_MODE    = 1;
    localparam int          ST_FROZEN      = 2;
endpackage

/* hw/serial_debug_port_shifter.sv */
// Serial debug port: shared shift register, trap enable control and debug pin muxing
// Summary of operation
// - One 35-bit serial shift register holds instructions and data for the tool.
// - Tool bits on serial input shift in on debug clock or clock output.
// - A completed frame goes in parallel to CPU or trap enable control.
// - Debug-mode instruction fetches read the shift register the tool loaded.
// - Reading the port data register returns the shift register contents.
// - Writing the port data register loads it, then shifts out serially.
// - Instruction and data registers are one physical shift register.
// - Shift register holds values on their way to trap enable control.
// - Trap enable control is 9 bits, loaded only from the shift register.
// - Trap enables, breakpoints and sync outputs come straight from its bits.
// - A trap transfer command copies shift register bits into trap control.
// - While frozen the flush status outputs read 0b11.
// - Debug pin config field picks watchpoint or flush; reset word sets it.
// - Freeze/trace pin starts as program trace, then follows pin config bits.
// - Alternate flush pins start as gp bits 3,4; select bit gives flush status.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
module serial_debug_port_shifter (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_debug_serial_clock,
    input  wire logic        i_debug_serial_in,
    output logic             o_debug_serial_out,
    output logic             o_system_clock_output,
    input  wire logic [2:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_cpu_frozen,
    input  wire logic [1:0]  i_flush_status,
    input  wire logic [1:0]  i_watchpoint,
    input  wire logic        i_program_trace,
    input  wire logic        i_gp_bit6_out,
    input  wire logic [1:0]  i_gp_bits34_out,
    input  wire logic [1:0]  i_reset_debug_pin_config_field,
    output logic      [5:0]  o_trap_enable,
    output logic      [1:0]  o_breakpoint,
    output logic             o_sync,
    output logic      [1:0]  o_watch_flush_pins,
    output logic      [1:0]  o_alt_flush_pins,
    output logic             o_freeze_trace_pin
);
    localparam int SW = dbg_port_pkg::SHIFT_W;

    if (dbg_port_pkg::SHIFT_W != dbg_port_pkg::DATA_W + 3) begin : g_chk
        $error("Shift register must be data width plus three framing bits");
    end

    // ---------------- Link domain (debug serial clock) ----------------
    logic          lrst_s1_ff;
    logic          lrst_s2_ff;
    logic          lframe_ff;
    logic [5:0]    lcnt_ff;
    logic [SW-1:0] lrx_ff;
    logic [SW-1:0] lrx_word_ff;
    logic          lrx_tgl_ff;
    logic          ltx_s1_ff;
    logic          ltx_s2_ff;
    logic          ltx_s3_ff;
    logic [SW-1:0] lout_ff;
    logic          lout_bit_ff;
    logic [SW-1:0] nxt_lrx;

    // Reset reaches the link clock through its own synchroniser
    always_ff @(posedge i_debug_serial_clock) begin
        lrst_s1_ff <= i_rst_n;
        lrst_s2_ff <= lrst_s1_ff;
    end

    assign nxt_lrx = {lrx_ff[SW-2:0], i_debug_serial_in};

    // Frame: a high start bit, then 34 more bits
    always_ff @(posedge i_debug_serial_clock) begin
        if (!lrst_s2_ff) begin
            lframe_ff   <= 1'b0;
            lcnt_ff     <= 6'h00;
            lrx_ff      <= dbg_port_pkg::SHIFT_RESET;
            lrx_word_ff <= dbg_port_pkg::SHIFT_RESET;
            lrx_tgl_ff  <= 1'b0;
        end else if (!lframe_ff) begin
            lrx_ff <= nxt_lrx;
            if (i_debug_serial_in) begin
                lframe_ff <= 1'b1;
                lcnt_ff   <= 6'h01;
            end
        end else begin
            lrx_ff  <= nxt_lrx;
            lcnt_ff <= lcnt_ff + 6'h01;
            if (lcnt_ff == dbg_port_pkg::LAST_BIT_IDX) begin
                // Word held stable until the next frame ends
                lrx_word_ff <= nxt_lrx;
                lrx_tgl_ff  <= ~lrx_tgl_ff;
                lframe_ff   <= 1'b0;
            end
        end
    end

    // Transmit word crosses by toggle; the word itself is already stable
    logic          tx_tgl_ff;
    logic [SW-1:0] tx_word_ff;

    always_ff @(posedge i_debug_serial_clock) begin
        ltx_s1_ff <= tx_tgl_ff;
        ltx_s2_ff <= ltx_s1_ff;
        ltx_s3_ff <= ltx_s2_ff;
    end

    // Limitation: a load during a frame overwrites bits still going out
    always_ff @(posedge i_debug_serial_clock) begin
        if (!lrst_s2_ff) begin
            lout_ff     <= dbg_port_pkg::SHIFT_RESET;
            lout_bit_ff <= 1'b0;
        end else if (ltx_s2_ff != ltx_s3_ff) begin
            lout_ff <= tx_word_ff;
        end else if (lframe_ff || i_debug_serial_in) begin
            lout_bit_ff <= lout_ff[SW-1];
            lout_ff     <= {lout_ff[SW-2:0], 1'b0};
        end
    end

    // ---------------- System domain ----------------
    logic          rx_s1_ff;
    logic          rx_s2_ff;
    logic          rx_s3_ff;
    logic          dout_s1_ff;
    logic          dout_s2_ff;
    logic          din_s1_ff;
    logic          din_s2_ff;
    logic          din_s3_ff;
    logic          div_ff;
    logic          cframe_ff;
    logic [5:0]    ccnt_ff;
    logic [SW-1:0] shift_ff;
    logic [8:0]    trap_ff;
    logic          rx_pend_ff;
    logic          clk_mode_ff;
    logic [1:0]    debug_pin_config_field_ff;
    logic [1:0]    gpc_ff;
    logic          flush_sel_ff;
    logic          strap_done_ff;

    always_ff @(posedge i_clk) begin
        rx_s1_ff   <= lrx_tgl_ff;
        rx_s2_ff   <= rx_s1_ff;
        rx_s3_ff   <= rx_s2_ff;
        dout_s1_ff <= lout_bit_ff;
        dout_s2_ff <= dout_s1_ff;
        din_s1_ff  <= i_debug_serial_in;
        din_s2_ff  <= din_s1_ff;
        din_s3_ff  <= din_s2_ff;
    end

    logic          link_done;
    logic          tick;
    logic          din_ok;
    logic          clk_done;
    logic          frame_done;
    logic [SW-1:0] nxt_shift;
    logic          trap_cmd;
    logic          cpu_word;
    logic          wr_data;
    logic          rd_cpu;

    assign link_done = !clk_mode_ff && (rx_s2_ff != rx_s3_ff);
    // Clock-output mode samples once per divided clock, on settled input
    assign tick      = clk_mode_ff && div_ff;
    assign din_ok    = din_s2_ff == din_s3_ff;
    assign clk_done  = tick && din_ok && cframe_ff && (ccnt_ff == dbg_port_pkg::LAST_BIT_IDX);
    assign frame_done = link_done || clk_done;
    assign wr_data   = i_wr && (i_addr == dbg_port_pkg::ADDR_DATA);
    assign rd_cpu    = i_rd && (i_addr == dbg_port_pkg::ADDR_INSTR
                                || i_addr == dbg_port_pkg::ADDR_DATA);

    // One register serves as instruction, data and trap holding register
    always_comb begin
        nxt_shift = shift_ff;
        if (link_done) begin
            nxt_shift = lrx_word_ff;
        end else if (tick && din_ok && (cframe_ff || din_s3_ff)) begin
            nxt_shift = {shift_ff[SW-2:0], din_s3_ff};
        end else if (wr_data) begin
            nxt_shift = {3'h0, i_wdata};
        end
    end

    assign trap_cmd = frame_done && nxt_shift[dbg_port_pkg::MODE_POS]
                      && !nxt_shift[dbg_port_pkg::CTRL_POS];
    assign cpu_word = frame_done && !nxt_shift[dbg_port_pkg::MODE_POS];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            shift_ff <= dbg_port_pkg::SHIFT_RESET;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_ff    <= 1'b0;
            cframe_ff <= 1'b0;
            ccnt_ff   <= 6'h00;
        end else begin
            div_ff <= ~div_ff;
            if (!clk_mode_ff || clk_done) begin
                cframe_ff <= 1'b0;
                ccnt_ff   <= 6'h00;
            end else if (tick && din_ok) begin
                if (cframe_ff) begin
                    ccnt_ff <= ccnt_ff + 6'h01;
                end else if (din_s3_ff) begin
                    cframe_ff <= 1'b1;
                    ccnt_ff   <= 6'h01;
                end
            end
        end
    end

    // Trap control changes from the shift register and nothing else
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            trap_ff <= dbg_port_pkg::TRAP_RESET;
        end else if (trap_cmd) begin
            trap_ff <= nxt_shift[dbg_port_pkg::TRAP_W-1:0];
        end
    end

    assign o_trap_enable = trap_ff[dbg_port_pkg::BRKPT_LSB-1:dbg_port_pkg::TRAP_EN_LSB];
    assign o_breakpoint  = trap_ff[dbg_port_pkg::SYNC_POS-1:dbg_port_pkg::BRKPT_LSB];
    assign o_sync        = trap_ff[dbg_port_pkg::SYNC_POS];

    // New word wins over a read in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_pend_ff <= 1'b0;
        end else if (cpu_word) begin
            rx_pend_ff <= 1'b1;
        end else if (rd_cpu) begin
            rx_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (rd_cpu) begin
            o_rdata <= shift_ff[dbg_port_pkg::DATA_W-1:0];
        end else if (i_rd && i_addr == dbg_port_pkg::ADDR_STATUS) begin
            o_rdata <= {29'h00000000, i_cpu_frozen, clk_mode_ff, rx_pend_ff};
        end else if (i_rd && i_addr == dbg_port_pkg::ADDR_CONFIG) begin
            o_rdata <= {26'h0000000, flush_sel_ff, gpc_ff, debug_pin_config_field_ff, clk_mode_ff};
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Transmit hand-off toward the link clock
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_tgl_ff  <= 1'b0;
            tx_word_ff <= dbg_port_pkg::SHIFT_RESET;
        end else if (wr_data && !clk_mode_ff) begin
            tx_word_ff <= {3'h0, i_wdata};
            tx_tgl_ff  <= ~tx_tgl_ff;
        end
    end

    // Strap taken on the first clock after reset release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            clk_mode_ff   <= dbg_port_pkg::CLK_MODE_RESET;
            debug_pin_config_field_ff       <= 2'h0;
            gpc_ff        <= dbg_port_pkg::GPC_RESET;
            flush_sel_ff  <= dbg_port_pkg::FLUSH_SEL_RST;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            debug_pin_config_field_ff       <= i_reset_debug_pin_config_field;
            strap_done_ff <= 1'b1;
        end else if (i_wr && i_addr == dbg_port_pkg::ADDR_CONFIG) begin
            clk_mode_ff  <= i_wdata[dbg_port_pkg::CFG_CLK_MODE];
            debug_pin_config_field_ff      <= i_wdata[dbg_port_pkg::CFG_DEBUG_PIN_CONFIG_FIELD_LSB +: 2];
            gpc_ff       <= i_wdata[dbg_port_pkg::CFG_GPC_LSB +: 2];
            flush_sel_ff <= i_wdata[dbg_port_pkg::CFG_FLUSH_SEL];
        end
    end

    logic [1:0] flush_val;
    assign flush_val = i_cpu_frozen ? dbg_port_pkg::FROZEN_FLUSH : i_flush_status;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_watch_flush_pins    <= 2'h0;
            o_alt_flush_pins      <= 2'h0;
            o_freeze_trace_pin    <= 1'b0;
            o_debug_serial_out    <= 1'b0;
            o_system_clock_output <= 1'b0;
        end else begin
            o_watch_flush_pins <= (debug_pin_config_field_ff == dbg_port_pkg::DEBUG_PIN_CONFIG_FIELD_FLUSH) ? flush_val
                                                                         : i_watchpoint;
            o_alt_flush_pins   <= flush_sel_ff ? flush_val : i_gp_bits34_out;
            case (gpc_ff)
                dbg_port_pkg::GPC_FREEZE: o_freeze_trace_pin <= i_cpu_frozen;
                dbg_port_pkg::GPC_GPIO:   o_freeze_trace_pin <= i_gp_bit6_out;
                default:                  o_freeze_trace_pin <= i_program_trace;
            endcase
            o_debug_serial_out    <= clk_mode_ff ? shift_ff[SW-1] : dout_s2_ff;
            o_system_clock_output <= clk_mode_ff ? div_ff : 1'b0;
        end
    end

    // ---------------- Assertions ----------------
    trap_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        trap_cmd |=> trap_ff == $past(nxt_shift[8:0]))
        else $error("Trap control not loaded from shift register");
    trap_source_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !trap_cmd |=> $stable(trap_ff))
        else $error("Trap control changed without transfer command");
    reset_clear_a: assert property (@(posedge i_clk)
        !i_rst_n |=> trap_ff == 9'h000 && shift_ff == 35'h000000000 && !o_sync)
        else $error("Reset did not clear trap and shift state");
    frozen_flush_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cpu_frozen && flush_sel_ff |=> o_alt_flush_pins == 2'h3)
        else $error("Frozen state not shown as 0b11");
    data_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && i_addr == 3'h1 |=> o_rdata == $past(shift_ff[31:0]))
        else $error("Data register read returned wrong word");
    data_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_data && !link_done && !tick |=> shift_ff == {3'h0, $past(i_wdata)})
        else $error("Data register write did not load shift register");
    fetch_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rx_pend_ff && rd_cpu && !cpu_word |=> !rx_pend_ff ##1 (!rx_pend_ff || $past(cpu_word)))
        else $error("Fetch did not consume pending word");
    trace_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rst_n && gpc_ff == 2'h0 ##1 gpc_ff == 2'h0 |-> o_freeze_trace_pin == $past(i_program_trace))
        else $error("Trace pin does not follow program trace");
    gp_pins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rst_n && !flush_sel_ff |=> o_alt_flush_pins == $past(i_gp_bits34_out))
        else $error("Alternate pins not carrying gp bits");
    link_count_a: assert property (@(posedge i_debug_serial_clock)
        disable iff (!lrst_s2_ff) lframe_ff |-> lcnt_ff <= 6'h22)
        else $error("Link frame longer than 35 bits");

    trap_load_c:  cover property (@(posedge i_clk) disable iff (!i_rst_n) trap_cmd);
    cpu_word_c:   cover property (@(posedge i_clk) disable iff (!i_rst_n) cpu_word ##[1:20] rd_cpu);
    data_write_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_data);
    clk_frame_c:  cover property (@(posedge i_clk) disable iff (!i_rst_n) clk_done);
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the serial debug port shifter
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cpu_frozen = 1'b0;
    logic [1:0]  flush_status = 2'h2;
    logic [1:0]  watchpoint = 2'h1;
    logic        program_trace = 1'b1;
    logic        gp_bit6_out = 1'b0;
    logic [1:0]  gp_bits34_out = 2'h1;
    logic [1:0]  reset_debug_pin_config_field = dbg_port_pkg::DEBUG_PIN_CONFIG_FIELD_FLUSH;
    logic        debug_serial_clock;
    logic        debug_serial_in;
    logic        dout;
    logic        clk_out;
    logic [31:0] rdata;
    logic [5:0]  trap_enable;
    logic [1:0]  breakpoint;
    logic        sync_out;
    logic [1:0]  watch_flush;
    logic [1:0]  alt_flush;
    logic        freeze_trace;
    int          n_fail = 0;
    int          checked = 0;
    logic [8:0]  trap_now;

    assign trap_now = {sync_out, breakpoint, trap_enable};

    always #20 clk = ~clk;

    tool_model tool_model_inst (.i_debug_serial_out(dout), .o_debug_serial_clock(debug_serial_clock),
        .o_debug_serial_in(debug_serial_in));

    serial_debug_port_shifter serial_debug_port_shifter_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_debug_serial_clock(debug_serial_clock),
        .i_debug_serial_in(debug_serial_in), .o_debug_serial_out(dout), .o_system_clock_output(clk_out),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_cpu_frozen(cpu_frozen), .i_flush_status(flush_status), .i_watchpoint(watchpoint),
        .i_program_trace(program_trace), .i_gp_bit6_out(gp_bit6_out),
        .i_gp_bits34_out(gp_bits34_out), .i_reset_debug_pin_config_field(reset_debug_pin_config_field),
        .o_trap_enable(trap_enable), .o_breakpoint(breakpoint), .o_sync(sync_out),
        .o_watch_flush_pins(watch_flush), .o_alt_flush_pins(alt_flush),
        .o_freeze_trace_pin(freeze_trace));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    function automatic logic [31:0] cfg(input logic fs, input logic [1:0] g,
                                        input logic [1:0] d, input logic cm);
        return (32'(fs) << dbg_port_pkg::CFG_FLUSH_SEL) | (32'(g) << dbg_port_pkg::CFG_GPC_LSB)
             | (32'(d) << dbg_port_pkg::CFG_DEBUG_PIN_CONFIG_FIELD_LSB) | 32'(cm);
    endfunction

    // Covers the toggle synchroniser plus the pending update
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        chk(32'(trap_now), 32'h0);
        chk(32'(freeze_trace), 32'h1);
        chk(32'(alt_flush), 32'(gp_bits34_out));
        chk(32'(watch_flush), 32'(flush_status));
        rd_chk(dbg_port_pkg::ADDR_CONFIG, cfg(1'b0, 2'h0, dbg_port_pkg::DEBUG_PIN_CONFIG_FIELD_FLUSH, 1'b0));
        rd_chk(dbg_port_pkg::ADDR_DATA, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_cpu_word;
        tool_model_inst.send_frame(1'b0, 1'b0, 32'hA5C3_1E77);
        settle(8);
        rd_chk(dbg_port_pkg::ADDR_STATUS, 32'h1 << dbg_port_pkg::ST_RX_PEND);
        rd_chk(dbg_port_pkg::ADDR_DATA, 32'hA5C3_1E77);
        rd_chk(dbg_port_pkg::ADDR_STATUS, 32'h0);
        tool_model_inst.send_frame(1'b0, 1'b0, 32'h0F1E_2D3C);
        settle(8);
        rd_chk(dbg_port_pkg::ADDR_INSTR, 32'h0F1E_2D3C);
        chk(32'(trap_now), 32'h0);
        $display("test cpu word done");
    endtask

    task automatic t_trap;
        tool_model_inst.send_frame(1'b1, 1'b0, 32'h1234_5DA5);
        settle(8);
        chk(32'(trap_now), 32'h1A5);
        chk(32'(breakpoint), 32'h2);
        rd_chk(dbg_port_pkg::ADDR_STATUS, 32'h0);
        tool_model_inst.send_frame(1'b1, 1'b1, 32'h0000_0000);
        settle(8);
        chk(32'(trap_now), 32'h1A5);
        reg_wr(dbg_port_pkg::ADDR_DATA, 32'h0000_0000);
        settle(2);
        chk(32'(trap_now), 32'h1A5);
        tool_model_inst.send_frame(1'b1, 1'b0, 32'hFFFF_FE00);
        settle(8);
        chk(32'(trap_now), 32'h0);
        $display("test trap done");
    endtask

    task automatic t_cpu_write;
        reg_wr(dbg_port_pkg::ADDR_DATA, 32'hCAFE_0123);
        rd_chk(dbg_port_pkg::ADDR_DATA, 32'hCAFE_0123);
        reg_wr(dbg_port_pkg::ADDR_INSTR, 32'h1111_1111);
        rd_chk(dbg_port_pkg::ADDR_DATA, 32'hCAFE_0123);
        // Word reaches the link only after three link edges
        tool_model_inst.idle_clocks(3);
        tool_model_inst.send_frame(1'b1, 1'b1, 32'h0000_0000);
        chk(tool_model_inst.seen_out[31:0], 32'hCAFE_0123);
        $display("test cpu write done");
    endtask

    // One-hot source pattern tells the three pin functions apart
    task automatic t_pins;
        for (int g = 0; g < 4; g++) begin
            reg_wr(dbg_port_pkg::ADDR_CONFIG, cfg(1'b0, 2'(g), 2'h0, 1'b0));
            for (int k = 0; k < 3; k++) begin
                @(posedge clk);
                program_trace <= (k == 0);
                cpu_frozen    <= (k == 1);
                gp_bit6_out   <= (k == 2);
                settle(3);
                chk(32'(freeze_trace), 32'((g == k) || (g == 3 && k == 0)));
            end
        end
        chk(32'(watch_flush), 32'(watchpoint));
        reg_wr(dbg_port_pkg::ADDR_CONFIG, cfg(1'b1, 2'h0, dbg_port_pkg::DEBUG_PIN_CONFIG_FIELD_FLUSH, 1'b0));
        @(posedge clk);
        cpu_frozen <= 1'b1;
        settle(3);
        chk(32'(watch_flush), 32'(dbg_port_pkg::FROZEN_FLUSH));
        chk(32'(alt_flush), 32'(dbg_port_pkg::FROZEN_FLUSH));
        rd_chk(dbg_port_pkg::ADDR_STATUS, 32'h1 << dbg_port_pkg::ST_FROZEN);
        @(posedge clk);
        cpu_frozen <= 1'b0;
        settle(3);
        chk(32'(alt_flush), 32'(flush_status));
        chk(32'(watch_flush), 32'(flush_status));
        $display("test pins done");
    endtask

    task automatic t_clock_mode;
        logic first;
        reg_wr(dbg_port_pkg::ADDR_CONFIG, cfg(1'b0, 2'h0, 2'h0, 1'b1));
        settle(3);
        first = clk_out;
        settle(1);
        chk(32'(first ^ clk_out), 32'h1);
        rd_chk(dbg_port_pkg::ADDR_STATUS, 32'h1 << dbg_port_pkg::ST_CLK_MODE);
        reg_wr(dbg_port_pkg::ADDR_CONFIG, cfg(1'b0, 2'h0, 2'h0, 1'b0));
        settle(3);
        chk(32'(clk_out), 32'h0);
        $display("test clock mode done");
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Link clock must run while reset is held, hence the longer hold
    initial begin
        fork
            tool_model_inst.idle_clocks(4);
            repeat (14) @(posedge clk);
        join
        rst_n <= 1'b1;
        // Link side needs edges after release to drop its own reset
        tool_model_inst.idle_clocks(3);
        settle(3);
        t_reset();
        t_cpu_word();
        t_trap();
        t_cpu_write();
        t_pins();
        t_clock_mode();
        finish_test();
    end

    initial begin
        #200us;
        n_fail++;
        finish_test();
    end
endmodule

/* testbench/tool_model.sv */
// Development tool model driving the serial debug link
module tool_model (
    input  logic i_debug_serial_out,
    output logic o_debug_serial_clock,
    output logic o_debug_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bits seen on the return line, newest in bit 0
    logic [34:0] seen_out;

    initial begin
        o_debug_serial_clock = 1'b0;
        o_debug_serial_in    = 1'b0;
        seen_out             = 35'h000000000;
    end

    // Data set while the clock is low, so it is stable at the rising edge
    task automatic link_bit(input logic b);
        o_debug_serial_in = b;
        #62.5 seen_out = {seen_out[33:0], i_debug_serial_out};
        o_debug_serial_clock = 1'b1;
        #62.5 o_debug_serial_clock = 1'b0;
    endtask

    // Line low means idle, so these edges never start a frame
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            link_bit(1'b0);
        end
    endtask

    // Start bit, mode, control, 32 data bits, MSB first; clock stops after
    task automatic send_frame(input logic mode, input logic ctrl, input logic [31:0] data);
        logic [34:0] word;
        word = {1'b1, mode, ctrl, data};
        for (int i = 34; i >= 0; i--) begin
            link_bit(word[i]);
        end
        o_debug_serial_in = 1'b0;
        // Last bit out shows up only after the final edge
        #62.5 seen_out = {seen_out[33:0], i_debug_serial_out};
    endtask
endmodule
